/* File: core/cosc_pkg.sv */
// constants, register map and carrier types for the clock output sync control
// assumes one distribution-path clock drives all logic that uses this package
package cosc_pkg;

   // block shape
   localparam int NUM_OUT = 6;
   localparam int OUT_SRC_A = 3;
   localparam int OUT_SRC_B = 4;

   // distribution clock rate, used only to relate cycles to time
   localparam int DIST_CLK_MHZ = 50;

   // register indices on the plain register port
   localparam logic [4:0] REG_OUT_FIRST = 5'h00;
   localparam logic [4:0] REG_OUT_LAST = 5'h05;
   localparam logic [4:0] REG_CTRL = 5'h06;
   localparam logic [4:0] REG_STAT = 5'h07;
   localparam logic [4:0] REG_FBDIV = 5'h1e;

   // per-output configuration fields
   localparam int F_DLY_LSB = 0;
   localparam int F_DLY_MSB = 9;
   localparam int F_HS = 10;
   localparam int F_EXEMPT = 11;
   localparam int F_SRC = 12;
   localparam int F_DIV_LSB = 16;
   localparam int F_DIV_MSB = 23;

   // control register fields
   localparam int C_EN = 0;
   localparam int C_INV = 1;
   localparam int C_TYPE_LSB = 2;
   localparam int C_TYPE_MSB = 4;
   localparam int C_PLL1 = 5;
   localparam int C_PLL2 = 6;
   localparam int C_AUTO = 7;
   localparam int C_QUAL = 8;
   localparam int C_QSEL_LSB = 9;
   localparam int C_QSEL_MSB = 11;
   localparam int C_INTOSC = 12;

   // feedback divider field width
   localparam int FBDIV_W = 18;

   // values and limits
   localparam logic [9:0] DLY_MIN = 10'h005;
   localparam logic [9:0] DLY_MAX = 10'h20a;
   localparam logic [7:0] DIV_RST = 8'h02;
   localparam logic [7:0] DIV_ONE = 8'h01;
   localparam logic [2:0] TYPE_FIRST_OUT = 3'h3;
   localparam logic [2:0] QSEL_RST = 3'h0;

   // sync timing in distribution cycles
   localparam int SYNC_LAT_CYC = 6;
   localparam int SYNC_PULSE_CYC = 4;
   localparam logic [2:0] PULSE_LOAD = 3'(SYNC_PULSE_CYC);

   // half-cycle stepping of the phase counter
   localparam logic [10:0] STEP_NORM = 11'h002;
   localparam logic [10:0] STEP_ADV = 11'h003;
   localparam logic [10:0] STEP_RET = 11'h001;
   localparam logic [10:0] WAIT_BASE = 11'(2 * SYNC_LAT_CYC);

   typedef struct packed {
      logic [7:0] div;
      logic src_ref;
      logic exempt;
      logic hs;
      logic [9:0] dly;
   } cosc_out_cfg_t;

   typedef struct packed {
      logic intosc;
      logic [2:0] qsel;
      logic qual;
      logic auto_sync;
      logic pll2_unlock;
      logic pll1_unlock;
      logic [2:0] sync_type;
      logic inv;
      logic en;
   } cosc_ctrl_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_HELD = 3'b010,
      ST_WAIT = 3'b100
   } cosc_state_t;

endpackage

/* File: core/cosc_sync_ctrl.sv */
// clock output sync control: divided outputs held, released and delayed on sync
// assumes sys_clk_in is the distribution-path clock and all inputs are synchronous to it
// Summary of operation
// - sync asserted holds selected outputs low
// - release raises outputs together, delay-shifted
// - exempt outputs keep toggling through sync
// - new coarse delay waits for next sync
// - half-step change acts right after write
// - global enable gates every sync source
// - pin polarity table per sync type
// - polarity bit toggle yields sync assertion
// - unlock sync while pll lock flag false
// - feedback divider write syncs on internal oscillator
// - auto sync on output register writes
// - assertion latched, outputs low six later
// - release latched, rise seven plus delay
// - half step five gives 11.5 cycles
// - all counts in distribution clock cycles
// - reference-sourced outputs not aligned by sync
// - outputs 3,4 sync only on internal source
// - later sync realigns outputs that are neither exempt nor reference-sourced
// - qualify sync against a chosen output
// - coarse delay 5..522, half step subtracts half
`timescale 1ns/100ps

module cosc_sync_ctrl (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [4:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // sync sources
   input wire logic sync_pin_in,
   input wire logic pll1_lock_in,
   input wire logic pll2_lock_in,
   // clock outputs, two half-cycle samples per cycle, bit 1 first
   output logic [cosc_pkg::NUM_OUT-1:0][1:0] clk_pair_out,
   // status
   output logic sync_held_out,
   output logic [cosc_pkg::FBDIV_W-1:0] pll2_fb_div_out
);

   // configuration state
   cosc_pkg::cosc_out_cfg_t out_cfg [cosc_pkg::NUM_OUT];
   cosc_pkg::cosc_ctrl_t ctrl;

   // sync path state
   logic pin_meta;
   logic pin_sync;
   logic [2:0] pulse_cnt;
   logic sync_latched;
   logic next_sync_latched;
   logic [cosc_pkg::SYNC_LAT_CYC-2:0] sync_dly;
   logic qual_last;
   logic qual_fall;
   logic sync_req;
   logic pin_assert;
   logic release_now;
   logic hold_go;
   logic [cosc_pkg::NUM_OUT-1:0] running;

   // write decode
   logic wr_out;
   logic wr_ctrl;
   logic wr_fb;
   logic inv_toggle;
   logic wr_event;

   // clamp coarse delay into its legal range
   function automatic logic [9:0] clamp_dly(input logic [9:0] d);
      if (d < cosc_pkg::DLY_MIN) begin
         return cosc_pkg::DLY_MIN;
      end else if (d > cosc_pkg::DLY_MAX) begin
         return cosc_pkg::DLY_MAX;
      end
      return d;
   endfunction

   // a divider of zero behaves as one so the output still toggles
   function automatic logic [7:0] eff_div(input logic [7:0] d);
      return (d == '0) ? cosc_pkg::DIV_ONE : d;
   endfunction

   // phase is in half cycles, period is twice the divider
   function automatic logic [9:0] wrap_ph(input logic [10:0] p, input logic [7:0] d);
      logic [10:0] per;
      logic [10:0] q;
      per = {2'b00, d, 1'b0};
      q = p;
      if (q >= per) begin
         q = q - per;
      end
      if (q >= per) begin
         q = q - per;
      end
      return q[9:0];
   endfunction

   // high for the first half of the period
   function automatic logic lvl(input logic [9:0] p, input logic [7:0] d);
      return p < {2'b00, d};
   endfunction

   assign wr_out = reg_wr_in && (reg_addr_in <= cosc_pkg::REG_OUT_LAST);
   assign wr_ctrl = reg_wr_in && (reg_addr_in == cosc_pkg::REG_CTRL);
   assign wr_fb = reg_wr_in && (reg_addr_in == cosc_pkg::REG_FBDIV);
   assign inv_toggle = wr_ctrl && (reg_wdata_in[cosc_pkg::C_INV] != ctrl.inv);
   // auto and divider writes start a pulse just like a polarity toggle
   assign wr_event = inv_toggle
                     || (wr_out && ctrl.auto_sync)
                     || (wr_fb && ctrl.intosc);

   // per-output configuration registers
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < cosc_pkg::NUM_OUT; i++) begin
            out_cfg[i] <= '{div: cosc_pkg::DIV_RST, src_ref: 1'b0, exempt: 1'b0, hs: 1'b0,
                            dly: cosc_pkg::DLY_MIN};
         end
      end else if (wr_out) begin
         for (int i = 0; i < cosc_pkg::NUM_OUT; i++) begin
            if (reg_addr_in == 5'(i)) begin
               out_cfg[i].dly <= clamp_dly(reg_wdata_in[cosc_pkg::F_DLY_MSB:cosc_pkg::F_DLY_LSB]);
               out_cfg[i].hs <= reg_wdata_in[cosc_pkg::F_HS];
               out_cfg[i].exempt <= reg_wdata_in[cosc_pkg::F_EXEMPT];
               // source select only exists on the two switchable outputs
               out_cfg[i].src_ref <= ((i == cosc_pkg::OUT_SRC_A) || (i == cosc_pkg::OUT_SRC_B))
                                     && reg_wdata_in[cosc_pkg::F_SRC];
               out_cfg[i].div <= reg_wdata_in[cosc_pkg::F_DIV_MSB:cosc_pkg::F_DIV_LSB];
            end
         end
      end
   end

   // control register, sync enabled out of reset
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl <= '{intosc: 1'b1, qsel: cosc_pkg::QSEL_RST, qual: 1'b0, auto_sync: 1'b0,
                   pll2_unlock: 1'b0, pll1_unlock: 1'b0, sync_type: '0, inv: 1'b0, en: 1'b1};
      end else if (wr_ctrl) begin
         ctrl.en <= reg_wdata_in[cosc_pkg::C_EN];
         ctrl.inv <= reg_wdata_in[cosc_pkg::C_INV];
         ctrl.sync_type <= reg_wdata_in[cosc_pkg::C_TYPE_MSB:cosc_pkg::C_TYPE_LSB];
         ctrl.pll1_unlock <= reg_wdata_in[cosc_pkg::C_PLL1];
         ctrl.pll2_unlock <= reg_wdata_in[cosc_pkg::C_PLL2];
         ctrl.auto_sync <= reg_wdata_in[cosc_pkg::C_AUTO];
         ctrl.qual <= reg_wdata_in[cosc_pkg::C_QUAL];
         ctrl.qsel <= reg_wdata_in[cosc_pkg::C_QSEL_MSB:cosc_pkg::C_QSEL_LSB];
         ctrl.intosc <= reg_wdata_in[cosc_pkg::C_INTOSC];
      end
   end

   // feedback divider value, only stored and shown
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pll2_fb_div_out <= '0;
      end else if (wr_fb) begin
         pll2_fb_div_out <= reg_wdata_in[cosc_pkg::FBDIV_W-1:0];
      end
   end

   // read data one cycle after the strobe, unmapped reads give zero
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= '0;
      end else if (reg_rd_in) begin
         reg_rdata_out <= '0;
         if (reg_addr_in <= cosc_pkg::REG_OUT_LAST) begin
            for (int i = 0; i < cosc_pkg::NUM_OUT; i++) begin
               if (reg_addr_in == 5'(i)) begin
                  reg_rdata_out[cosc_pkg::F_DLY_MSB:cosc_pkg::F_DLY_LSB] <= out_cfg[i].dly;
                  reg_rdata_out[cosc_pkg::F_HS] <= out_cfg[i].hs;
                  reg_rdata_out[cosc_pkg::F_EXEMPT] <= out_cfg[i].exempt;
                  reg_rdata_out[cosc_pkg::F_SRC] <= out_cfg[i].src_ref;
                  reg_rdata_out[cosc_pkg::F_DIV_MSB:cosc_pkg::F_DIV_LSB] <= out_cfg[i].div;
               end
            end
         end else if (reg_addr_in == cosc_pkg::REG_CTRL) begin
            reg_rdata_out[cosc_pkg::C_INTOSC:cosc_pkg::C_EN] <= ctrl;
         end else if (reg_addr_in == cosc_pkg::REG_STAT) begin
            reg_rdata_out[0] <= sync_latched;
            reg_rdata_out[1] <= sync_req;
            reg_rdata_out[cosc_pkg::NUM_OUT+1:2] <= running;
         end else if (reg_addr_in == cosc_pkg::REG_FBDIV) begin
            reg_rdata_out[cosc_pkg::FBDIV_W-1:0] <= pll2_fb_div_out;
         end
      end
   end

   // two flops on the pin; only the second one is looked at
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= sync_pin_in;
         pin_sync <= pin_meta;
      end
   end

   // register-made events stretch to several cycles so the latch always sees them
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pulse_cnt <= '0;
      end else if (wr_event) begin
         pulse_cnt <= cosc_pkg::PULSE_LOAD;
      end else if (pulse_cnt != '0) begin
         pulse_cnt <= pulse_cnt - 3'h1;
      end
   end

   // input types follow the pin, output types follow the invert bit alone
   assign pin_assert = (ctrl.sync_type >= cosc_pkg::TYPE_FIRST_OUT) ? ctrl.inv
                       : (pin_sync != ctrl.inv);

   // every source is gated by the global enable
   assign sync_req = ctrl.en && (pin_assert
                                 || (pulse_cnt != '0)
                                 || (ctrl.pll1_unlock && !pll1_lock_in)
                                 || (ctrl.pll2_unlock && !pll2_lock_in));

   // falling edge of the qualifying output, seen across and inside a pair
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         qual_last <= 1'b0;
      end else begin
         qual_last <= clk_pair_out[ctrl.qsel][0];
      end
   end

   assign qual_fall = (ctrl.qsel < 3'(cosc_pkg::NUM_OUT))
                      && ((qual_last && !clk_pair_out[ctrl.qsel][1])
                          || (clk_pair_out[ctrl.qsel][1] && !clk_pair_out[ctrl.qsel][0]));

   // latch follows the request, or only on qualifying edges when qualified
   always_comb begin
      next_sync_latched = sync_req;
      if (ctrl.qual && !qual_fall) begin
         next_sync_latched = sync_latched;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_latched <= 1'b0;
         sync_dly <= '0;
      end else begin
         sync_latched <= next_sync_latched;
         // counting in distribution clock cycles
         sync_dly <= {sync_dly[cosc_pkg::SYNC_LAT_CYC-3:0], sync_latched};
      end
   end

   // outputs go low six cycles after the assertion latch
   assign hold_go = sync_latched && sync_dly[cosc_pkg::SYNC_LAT_CYC-2];
   // release is seen on the same edge that latches it
   assign release_now = sync_latched && !next_sync_latched;
   assign sync_held_out = sync_latched;

   // one output channel each
   for (genvar i = 0; i < cosc_pkg::NUM_OUT; i++) begin : g_out
      cosc_pkg::cosc_state_t state;
      cosc_pkg::cosc_state_t next_state;
      logic [10:0] wait_h;
      logic [10:0] next_wait;
      logic [9:0] ph;
      logic [9:0] next_ph;
      logic [1:0] next_pair;
      logic [7:0] dv;
      logic hs_q;
      logic affected;
      logic [10:0] step;

      assign dv = eff_div(out_cfg[i].div);
      // reference-sourced outputs are left alone, as are exempt ones
      assign affected = !out_cfg[i].exempt && !out_cfg[i].src_ref;

      always_comb begin
         next_state = state;
         next_wait = wait_h;
         next_ph = ph;
         next_pair = '0;
         step = cosc_pkg::STEP_NORM;
         if (out_cfg[i].hs && !hs_q) begin
            step = cosc_pkg::STEP_ADV;
         end else if (!out_cfg[i].hs && hs_q) begin
            step = cosc_pkg::STEP_RET;
         end
         case (state)
            cosc_pkg::ST_RUN: begin
               next_pair = {lvl(ph, dv), lvl(wrap_ph({1'b0, ph} + 11'h001, dv), dv)};
               next_ph = wrap_ph({1'b0, ph} + step, dv);
            end
            cosc_pkg::ST_HELD: begin
               next_pair = '0;
            end
            cosc_pkg::ST_WAIT: begin
               if (wait_h >= 11'h002) begin
                  next_wait = wait_h - 11'h002;
               end else if (wait_h == 11'h001) begin
                  // rise lands on the second half of this cycle
                  next_pair = {1'b0, lvl('0, dv)};
                  next_ph = 10'h001;
                  next_state = cosc_pkg::ST_RUN;
               end else begin
                  next_pair = {lvl('0, dv), lvl(10'h001, dv)};
                  next_ph = wrap_ph(cosc_pkg::STEP_NORM, dv);
                  next_state = cosc_pkg::ST_RUN;
               end
            end
            default: begin
               next_state = cosc_pkg::ST_RUN;
            end
         endcase
         if (!affected) begin
            // exempt output carries on untouched
            if (state != cosc_pkg::ST_RUN) begin
               next_state = cosc_pkg::ST_RUN;
            end
         end else if (release_now) begin
            // delay taken from the current register only here
            next_state = cosc_pkg::ST_WAIT;
            next_wait = cosc_pkg::WAIT_BASE + {out_cfg[i].dly, 1'b0}
                        - {10'h000, out_cfg[i].hs};
         end else if (hold_go) begin
            next_state = cosc_pkg::ST_HELD;
            next_pair = '0;
         end
      end

      // phase, wait count and output samples
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            state <= cosc_pkg::ST_RUN;
            wait_h <= '0;
            ph <= '0;
            hs_q <= 1'b0;
            clk_pair_out[i] <= '0;
         end else begin
            state <= next_state;
            wait_h <= next_wait;
            ph <= next_ph;
            hs_q <= out_cfg[i].hs;
            clk_pair_out[i] <= next_pair;
         end
      end

      assign running[i] = (state == cosc_pkg::ST_RUN);
   end

endmodule

/* File: sim/cosc_sync_ctrl_sva.sv */
// checker for the clock output sync control, bound to its top module
// assumes outputs 0 and 5 keep divider 2, output 0 keeps delay 5, no qualify
`timescale 1ns/100ps
module cosc_sync_ctrl_sva (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [4:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   // sync sources
   input wire logic sync_pin_in,
   input wire logic pll1_lock_in,
   input wire logic pll2_lock_in,
   // outputs and status
   input wire logic [cosc_pkg::NUM_OUT-1:0][1:0] clk_pair_out,
   input wire logic sync_held_out,
   input wire logic [cosc_pkg::FBDIV_W-1:0] pll2_fb_div_out
);
   cosc_pkg::cosc_ctrl_t ctl;
   logic ex5;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // shadow of control word, exempt flag of output 5 only while it divides by 2
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctl <= cosc_pkg::cosc_ctrl_t'(13'h1001);
         ex5 <= 1'b0;
      end else if (reg_wr_in && reg_addr_in == cosc_pkg::REG_CTRL) begin
         ctl <= cosc_pkg::cosc_ctrl_t'(reg_wdata_in[12:0]);
      end else if (reg_wr_in && reg_addr_in == cosc_pkg::REG_OUT_LAST) begin
         ex5 <= reg_wdata_in[cosc_pkg::F_EXEMPT] && reg_wdata_in[23:16] == cosc_pkg::DIV_RST;
      end
   end
   property p_hold_low;
      $rose(sync_held_out) |-> ##6 (clk_pair_out[0] == 2'b00)[*4];
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("output not low after sync latch");
   property p_rise;
      $fell(sync_held_out) |-> ##6 (clk_pair_out[0] == 2'b00)[*3] ##[1:6] (clk_pair_out[0] != 2'b00);
   endproperty
   a_rise: assert property (p_rise) else $error("output rise after release misplaced");
   property p_exempt;
      ex5 && $past(ex5, 2) |-> clk_pair_out[5] != $past(clk_pair_out[5]);
   endproperty
   a_exempt: assert property (p_exempt) else $error("exempt output stopped");
   property p_en;
      !ctl.en && !$past(ctl.en, 2) |-> !$rose(sync_held_out);
   endproperty
   a_en: assert property (p_en) else $error("sync while disabled");
   property p_unlock;
      (ctl.en && ((ctl.pll1_unlock && !pll1_lock_in) || (ctl.pll2_unlock && !pll2_lock_in)))[*4] |-> sync_held_out;
   endproperty
   a_unlock: assert property (p_unlock) else $error("no sync on unlock");
   property p_pin;
      (ctl.en && ctl.sync_type < cosc_pkg::TYPE_FIRST_OUT && sync_pin_in != ctl.inv)[*6] |-> sync_held_out;
   endproperty
   a_pin: assert property (p_pin) else $error("pin sync not latched");
   property p_out_type;
      (ctl.en && ctl.sync_type >= cosc_pkg::TYPE_FIRST_OUT && ctl.inv)[*4] |-> sync_held_out;
   endproperty
   a_out_type: assert property (p_out_type) else $error("output type invert not held");
   property p_auto;
      reg_wr_in && reg_addr_in <= cosc_pkg::REG_OUT_LAST && ctl.auto_sync && ctl.en |-> ##[1:4] sync_held_out;
   endproperty
   a_auto: assert property (p_auto) else $error("no auto sync on write");
   property p_fb;
      reg_wr_in && reg_addr_in == cosc_pkg::REG_FBDIV |=> pll2_fb_div_out == $past(reg_wdata_in[17:0]);
   endproperty
   a_fb: assert property (p_fb) else $error("divider not stored");
   property p_fb_sync;
      reg_wr_in && reg_addr_in == cosc_pkg::REG_FBDIV && ctl.intosc && ctl.en |-> ##[1:4] sync_held_out;
   endproperty
   a_fb_sync: assert property (p_fb_sync) else $error("no sync on divider write");
   property p_unmapped;
      reg_rd_in && reg_addr_in > cosc_pkg::REG_STAT && reg_addr_in != cosc_pkg::REG_FBDIV |=> reg_rdata_out == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind cosc_sync_ctrl cosc_sync_ctrl_sva u_sva (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .sync_pin_in(sync_pin_in), .pll1_lock_in(pll1_lock_in),
   .pll2_lock_in(pll2_lock_in), .clk_pair_out(clk_pair_out), .sync_held_out(sync_held_out),
   .pll2_fb_div_out(pll2_fb_div_out));

/* File: sim/cosc_host_model.sv */
// host-side model: drives the sync pin and the two lock flags
// assumes the bench sends one-cycle start pulses with a hold length
`timescale 1ns/100ps
module cosc_host_model (
   // clock
   input wire logic clk_in,
   // commands from the bench
   input wire logic start_in,
   input wire logic [7:0] hold_in,
   input wire logic [1:0] unlock_in,
   // lines toward the device
   output logic sync_pin_out,
   output logic pll1_lock_out,
   output logic pll2_lock_out
);
   logic [7:0] left = 8'h00;
   // pulse never shorter than two cycles, else the latch may miss it
   always_ff @(posedge clk_in) begin
      if (start_in) begin
         left <= (hold_in < 8'h02) ? 8'h02 : hold_in;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   // pin high asserts with polarity clear
   assign sync_pin_out = (left != 8'h00);
   assign pll1_lock_out = !unlock_in[0];
   assign pll2_lock_out = !unlock_in[1];
endmodule

/* File: sim/cosc_sync_ctrl_tb_top.sv */
// self-checking bench for the clock output sync control
// assumes the checker is bound in and the host model drives the sync lines
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module cosc_sync_ctrl_tb_top;
   typedef struct {string n; logic [31:0] v; logic [31:0] m;} cosc_exp_t;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic start = 1'b0;
   logic [7:0] hold = 8'h00;
   logic [1:0] unl = 2'b00;
   logic [31:0] rdata;
   logic pin, l1, l2, held, pend, hp, armed, watch;
   logic [cosc_pkg::NUM_OUT-1:0][1:0] pair;
   logic [cosc_pkg::FBDIV_W-1:0] fb;
   logic [1:0] p3, p5;
   logic [1:0] pv[3];
   logic [31:0] seed = 32'h0000_9fa1;
   int r[3];
   int cnt, probe, mismatches, tests_run;
   cosc_exp_t q[$];
   initial begin
      {pend, hp, armed, watch, probe, mismatches, tests_run} = '0;
   end
   always #10 sys_clk_in = ~sys_clk_in;
   cosc_sync_ctrl dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .sync_pin_in(pin), .pll1_lock_in(l1),
      .pll2_lock_in(l2), .clk_pair_out(pair), .sync_held_out(held), .pll2_fb_div_out(fb));
   cosc_host_model host (.clk_in(sys_clk_in), .start_in(start), .hold_in(hold), .unlock_in(unl),
      .sync_pin_out(pin), .pll1_lock_out(l1), .pll2_lock_out(l2));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cyc(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge sys_clk_in);
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   // expected read data noted now, compared by the monitor
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m, input string n);
      q.push_back('{n, v, m});
      addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   task automatic probe_chk(input int k, input string n);
      q.push_back('{n, 32'h0000_0001, 32'hffff_ffff});
      probe <= k;
      cyc(1);
      probe <= 0;
      cyc(1);
   endtask
   task automatic pulse(input logic [7:0] h);
      // strobes from a preceding write must not stand for a second cycle
      wr <= 1'b0;
      rd <= 1'b0;
      hold <= h;
      start <= 1'b1;
      @(posedge sys_clk_in);
      start <= 1'b0;
   endtask
   task automatic check(input logic [31:0] got);
      cosc_exp_t e;
      e = (q.size() != 0) ? q.pop_front() : '{"nothing pending", 'x, 32'hffff_ffff};
      `CHK(e.n, e.v & e.m, got & e.m)
   endtask
   task automatic close_out;
      mismatches += q.size();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // monitor: read data, probes, and rise order after a watched release
   always @(posedge sys_clk_in) begin
      if (pend) check(rdata);
      pend = rd;
      if (probe == 1) check(32'(pair[2] === pair[0]));
      if (probe == 2) check(32'(pair[1] === {pair[0][0], ~pair[0][0]}));
      if (probe == 3) check(32'(pair[0] === 2'b00 && pair[4] === 2'b00 && pair[3] !== p3 && pair[5] !== p5));
      if (hp && !held && watch) begin
         armed = 1'b1;
         cnt = 0;
         r = '{-1, -1, -1};
      end
      if (armed) begin
         foreach (r[i]) if (r[i] < 0 && pair[i] !== 2'b00) begin
            r[i] = cnt;
            pv[i] = pair[i];
         end
         cnt++;
         if (r[0] >= 0 && r[1] >= 0 && r[2] >= 0) begin
            armed = 1'b0;
            check({8'(r[1] - r[0]), 8'(r[2] - r[0]), 10'h000, pv[0], pv[1], pv[2]});
         end
      end
      hp = held;
      p3 = pair[3];
      p5 = pair[5];
   end
   // watchdog, far beyond the planned run of under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk_in);
      mismatches++;
      close_out();
   end
   initial begin
      cyc(5);
      rst_n_in <= 1'b1;
      cyc(1);
      rd_chk(cosc_pkg::REG_OUT_FIRST, 32'h0002_0005, 32'h00ff_1fff, "out0 reset");
      rd_chk(cosc_pkg::REG_CTRL, 32'h0000_1001, 32'h0000_1fff, "ctrl reset");
      rd_chk(5'h08, 32'h0000_0000, 32'hffff_ffff, "unmapped");
      rd_chk(cosc_pkg::REG_STAT, 32'h0000_00fc, 32'h0000_00ff, "status idle");
      wr_reg(5'h03, 32'h0002_1005);
      wr_reg(5'h05, 32'h0002_0805);
      wr_reg(5'h02, 32'h0002_0007);
      wr_reg(5'h01, 32'h0002_0405);
      cyc(3);
      probe_chk(1, "delay waits for sync");
      probe_chk(2, "half step at once");
      watch <= 1'b1;
      seed = xs(seed);
      pulse(8'h0a + 8'(seed[3:0]));
      cyc(11);
      probe_chk(3, "held and exempt");
      q.push_back('{"rise order", 32'hff02_0037, 32'hffff_ffff});
      cyc(50);
      watch <= 1'b0;
      wr_reg(cosc_pkg::REG_CTRL, 32'h0000_1003);
      cyc(8);
      rd_chk(cosc_pkg::REG_STAT, 32'h0000_0001, 32'h0000_0001, "inverted idle");
      wr_reg(cosc_pkg::REG_CTRL, 32'h0000_100d);
      cyc(10);
      pulse(8'h14);
      cyc(6);
      rd_chk(cosc_pkg::REG_STAT, 32'h0000_0000, 32'h0000_0001, "pin ignored");
      cyc(25);
      wr_reg(cosc_pkg::REG_CTRL, 32'h0000_100f);
      cyc(8);
      rd_chk(cosc_pkg::REG_STAT, 32'h0000_0001, 32'h0000_0001, "output type low");
      wr_reg(cosc_pkg::REG_CTRL, 32'h0000_1001);
      cyc(30);
      wr_reg(cosc_pkg::REG_CTRL, 32'h0000_1000);
      pulse(8'h14);
      cyc(8);
      rd_chk(cosc_pkg::REG_STAT, 32'h0000_0000, 32'h0000_0001, "disabled");
      cyc(20);
      for (int k = 0; k < 2; k++) begin
         wr_reg(cosc_pkg::REG_CTRL, (k == 0) ? 32'h0000_1021 : 32'h0000_1041);
         unl <= 2'(k + 1);
         cyc(8);
         rd_chk(cosc_pkg::REG_STAT, 32'h0000_0001, 32'h0000_0001, "unlock");
         unl <= 2'b00;
         cyc(30);
      end
      wr_reg(cosc_pkg::REG_CTRL, 32'h0000_1081);
      wr_reg(5'h04, 32'h0002_0005);
      cyc(2);
      rd_chk(cosc_pkg::REG_STAT, 32'h0000_0001, 32'h0000_0001, "auto sync");
      cyc(30);
      wr_reg(cosc_pkg::REG_CTRL, 32'h0000_1001);
      repeat (3) begin
         seed = xs(seed);
         wr_reg(cosc_pkg::REG_FBDIV, {14'h0000, seed[17:0]});
         cyc(2);
         rd_chk(cosc_pkg::REG_STAT, 32'h0000_0001, 32'h0000_0001, "divider sync");
         rd_chk(cosc_pkg::REG_FBDIV, {14'h0000, seed[17:0]}, 32'h0003_ffff, "divider");
         cyc(30);
      end
      wr_reg(cosc_pkg::REG_CTRL, 32'h0000_0001);
      wr_reg(cosc_pkg::REG_FBDIV, 32'h0000_0123);
      cyc(2);
      rd_chk(cosc_pkg::REG_STAT, 32'h0000_0000, 32'h0000_0001, "no divider sync");
      cyc(5);
      close_out();
   end
endmodule
